// *** rtl/dcc_monitor.v ***
// Debug channel mailboxes, monitor-mode abort flag and scan identity
// Assumes the scan clock arrives as a pin and is sampled by core clock
//
// How it works
// R01: One-bit debug abort flag, read/write, bit 0
// R02: Breakpoint or watchpoint abort sets the flag
// R03: External abort wins; flag left unchanged
// R04: Core write of outgoing word sets write-full
// R05: Firmware polls write-full before writing again
// R06: Debugger reads outgoing only when write-full set
// R07: Debugger read of outgoing clears write-full
// R08: Debugger writes incoming only when read-full clear
// R09: Debugger write of incoming sets read-full
// R10: Core read of incoming clears read-full
// R11: Control bit 4 selects monitor mode aborts
// R12: Monitor mode blocks data range matches
// R13: Monitor mode disables single-step and external matches
// R14: Debugger must not catch abort vectors
// R15: No halt requests while in monitor mode
// R16: Comparator matches suppressed during register update
// R17: Debugger disables unit before reprogramming it
// R18: Identity loaded from identity input pins
// R19: Identity layout revision, product, maker, one
// R20: Status bit 1 reports write-full
// R21: Status bit 0 reports read-full
// R22: Both mailbox data registers are 32 bits
// R23: Reset clears both full flags and abort flag
`timescale 1ns/1ns
`include "dcc_monitor_regs.vh"
module dcc_monitor (
  input  wire        i_core_clk,
  input  wire        i_rst,
  // Coprocessor transfer port
  input  wire        i_cp_valid,
  input  wire        i_cp_write,
  input  wire [1:0]  i_cp_reg,
  input  wire [31:0] i_cp_wdata,
  output reg  [31:0] o_cp_rdata,
  output reg         o_cp_rvalid,
  // Abort causes from the core
  input  wire        i_bkpt_match,
  input  wire        i_wpt_match,
  input  wire        i_ext_abort,
  input  wire        i_halt_step_req,
  input  wire        i_ext_bkpt,
  input  wire        i_wpt_reg_update,
  input  wire        i_data_range_match,
  output reg         o_prefetch_abort,
  output reg         o_data_abort,
  output reg         o_debug_halt,
  output reg         o_debug_abort_flag,
  output reg         o_monitor_mode,
  // Identity inputs and serial scan pins
  input  wire [31:0] i_scan_port_ident_inputs,
  input  wire        i_tck,
  input  wire        i_tms_sel,
  input  wire        i_tdi,
  output reg         o_tdo
);
  // Synchronisers for the scan pins
  reg        tck_s1;
  reg        tck_s2;
  reg        tck_d;
  reg        sel_s1;
  reg        sel_s2;
  reg        tdi_s1;
  reg        tdi_s2;
  wire       tck_rise;
  wire       tck_fall;
  // Scan shifter: 3-bit select, 1 write bit, 31..0 data
  reg [`SH_W-1:0] shreg;
  reg [5:0]  shcnt;
  reg        sel_d;
  // Mailboxes and flags
  reg [31:0] in_word;
  reg        rfull;
  reg        wfull;
  reg [7:0]  dbg_ctl;
  reg [31:0] ident;
  // FIFO handshake
  wire       f_in_ready;
  wire [31:0] f_out_data;
  wire       f_out_valid;
  wire       f_pop;
  wire       cp_out_wr;
  wire [2:0] sc_sel;
  wire       sc_wr;
  wire       frame_end;
  wire       mon;
  wire       bk_ok;
  wire       wp_ok;
  reg [31:0] next_rdata;
  reg [31:0] sc_rd;

  assign tck_rise  = tck_s2 && !tck_d;
  assign tck_fall  = !tck_s2 && tck_d;
  assign sc_sel    = shreg[`SH_W-1:`SH_W-3];
  assign sc_wr     = shreg[`SH_W-4];
  assign frame_end = sel_d && !sel_s2 && (shcnt == `SH_BITS);
  assign mon       = dbg_ctl[`CTL_MONITOR];
  // Write only while the outgoing word is free
  assign cp_out_wr = i_cp_valid && i_cp_write && i_cp_reg == `CP_DATA &&
                     !wfull && f_in_ready; // R05
  // Outgoing word taken when debugger reads it
  assign f_pop     = frame_end && !sc_wr && sc_sel == `SC_OUT_DATA &&
                     wfull && f_out_valid; // R06
  // Comparator matches gated by mode limits and update cycle
  // External match inputs only ever feed the halt path
  assign bk_ok = i_bkpt_match && !i_wpt_reg_update && // R16
                 !(mon && i_data_range_match); // R12
  assign wp_ok = i_wpt_match && !i_wpt_reg_update && // R16
                 !(mon && i_data_range_match); // R12

  // Outgoing words travel through the buffer
  dcc_word_fifo #(
    .WIDTH (32),
    .DEPTH (`FIFO_DEPTH),
    .AW    (3)
  ) u_out_fifo (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_in_data   (i_cp_wdata),
    .i_in_valid  (cp_out_wr),
    .o_in_ready  (f_in_ready),
    .o_out_data  (f_out_data),
    .o_out_valid (f_out_valid),
    .i_out_ready (f_pop)
  );

  // Pin synchronisers and edge tracking
  always @(posedge i_core_clk)
  begin
    tck_s1 <= i_tck;
    tck_s2 <= tck_s1;
    tck_d  <= tck_s2;
    sel_s1 <= i_tms_sel;
    sel_s2 <= sel_s1;
    sel_d  <= sel_s2;
    tdi_s1 <= i_tdi;
    tdi_s2 <= tdi_s1;
  end

  // Scan-side read data; select sits low just before the fourth bit
  always @*
  begin
    case (shreg[`SH_SEL_W-1:0])
      `SC_STATUS:
      begin
        sc_rd = `WORD_ZERO;
        sc_rd[`ST_VER_HI:`ST_VER_LO] = `ST_VERSION;
        sc_rd[`ST_WFULL] = wfull; // R20
        sc_rd[`ST_RFULL] = rfull; // R21
      end
      `SC_OUT_DATA: sc_rd = f_out_data;
      `SC_IDENT:    sc_rd = ident;
      `SC_CONTROL:  sc_rd = {24'h00_0000, dbg_ctl};
      default:      sc_rd = `WORD_ZERO;
    endcase
  end

  // Core-side read data by register
  always @*
  begin
    case (i_cp_reg)
      `CP_STATUS:
      begin
        next_rdata = `WORD_ZERO;
        next_rdata[`ST_VER_HI:`ST_VER_LO] = `ST_VERSION;
        next_rdata[`ST_WFULL] = wfull; // R20
        next_rdata[`ST_RFULL] = rfull; // R21
      end
      `CP_DATA: next_rdata = in_word; // R22
      `CP_MON:  next_rdata = {31'h0000_0000, o_debug_abort_flag}; // R01
      default:  next_rdata = `WORD_ZERO;
    endcase
  end

  // Serial shifter: shift on rising edge, output on falling
  always @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      shreg <= {`SH_W{1'b0}};
      shcnt <= 6'h00;
      o_tdo <= 1'b0;
    end
    else if (sel_s2 && !sel_d)
    begin
      shcnt <= 6'h00;
    end
    else if (sel_s2 && tck_rise)
    begin
      shcnt <= shcnt + 6'h01;
      // Header complete: park select and write bit, load read data
      if (shcnt == `SH_HDR)
        shreg <= {shreg[`SH_SEL_W-1:0], tdi_s2, sc_rd};
      // Data phase shifts the word only, header stays parked
      else if (shcnt > `SH_HDR)
        shreg <= {shreg[`SH_W-1:`SH_D_W], shreg[`SH_D_W-2:0], tdi_s2};
      else
        shreg <= {shreg[`SH_W-2:0], tdi_s2};
    end
    else if (tck_fall)
    begin
      o_tdo <= shreg[`SH_D_W-1];
    end
  end

  // Mailbox flags, control and identity
  always @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      rfull   <= 1'b0; // R23
      wfull   <= 1'b0; // R23
      in_word <= `WORD_ZERO;
      dbg_ctl <= `CTL_RESET;
      ident   <= `WORD_ZERO;
    end
    else
    begin
      // Identity taken from the pins, bit 0 forced to one
      ident <= {i_scan_port_ident_inputs[`ID_REV_HI:`ID_REV_LO],
                i_scan_port_ident_inputs[`ID_PROD_HI:`ID_PROD_LO],
                i_scan_port_ident_inputs[`ID_MFR_HI:`ID_MFR_LO],
                `ID_LSB}; // R18 R19
      if (cp_out_wr)
        wfull <= 1'b1; // R04
      else if (f_pop)
        wfull <= 1'b0; // R07
      if (frame_end && sc_wr && sc_sel == `SC_IN_DATA && !rfull) // R08
      begin
        in_word <= shreg[31:0];
        rfull   <= 1'b1; // R09
      end
      else if (i_cp_valid && !i_cp_write && i_cp_reg == `CP_DATA)
        rfull <= 1'b0; // R10
      if (frame_end && sc_wr && sc_sel == `SC_CONTROL)
        dbg_ctl <= shreg[`CTL_W-1:0];
    end
  end

  // Abort routing, abort flag and read answer
  always @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_debug_abort_flag <= 1'b0; // R23
      o_cp_rdata         <= `WORD_ZERO;
      o_cp_rvalid        <= 1'b0;
      o_prefetch_abort   <= 1'b0;
      o_data_abort       <= 1'b0;
      o_debug_halt       <= 1'b0;
      o_monitor_mode     <= 1'b0;
    end
    else
    begin
      o_monitor_mode   <= mon; // R11
      o_cp_rvalid      <= i_cp_valid && !i_cp_write;
      o_cp_rdata       <= next_rdata;
      // Monitor mode aborts instead of halting
      o_prefetch_abort <= i_ext_abort || (mon && bk_ok); // R11
      o_data_abort     <= mon && wp_ok && !bk_ok; // R11
      // Halt mode only; no step in monitor mode
      o_debug_halt     <= !mon && (bk_ok || wp_ok || i_halt_step_req ||
                          i_ext_bkpt); // R13 R15
      // Abort event wins over software write
      if (mon && (bk_ok || wp_ok) && !i_ext_abort) // R03
        o_debug_abort_flag <= 1'b1; // R02
      else if (i_cp_valid && i_cp_write && i_cp_reg == `CP_MON)
        o_debug_abort_flag <= i_cp_wdata[0]; // R01
    end
  end
endmodule

// *** inc/dcc_monitor_regs.vh ***
// Constants for the debug channel and monitor-mode status block
// Assumes a single core clock; included by bare name
`ifndef DCC_MONITOR_REGS_VH
`define DCC_MONITOR_REGS_VH
// Coprocessor register numbers on the core side
`define CP_STATUS        2'h0
`define CP_DATA          2'h1
`define CP_MON           2'h2
// Scan register select codes on the debugger side
`define SC_STATUS        3'h0
`define SC_OUT_DATA      3'h1
`define SC_IN_DATA       3'h2
`define SC_IDENT         3'h3
`define SC_CONTROL       3'h4
// Channel status field positions
`define ST_WFULL         1
`define ST_RFULL         0
`define ST_VER_HI        31
`define ST_VER_LO        28
`define ST_VERSION       4'h0
// Debug control field positions
`define CTL_MONITOR      4
`define CTL_W            8
`define CTL_RESET        8'h00
// Identification layout
`define ID_REV_HI        31
`define ID_REV_LO        28
`define ID_PROD_HI       27
`define ID_PROD_LO       12
`define ID_MFR_HI        11
`define ID_MFR_LO        1
`define ID_LSB           1'b1
// Scan shift register width and frame length
`define SH_W             36
`define SH_BITS          6'h24
`define SH_HDR           6'h03
`define SH_SEL_W         3
`define SH_D_W           32
`define WORD_ZERO        32'h0000_0000
`define FIFO_DEPTH       8
`endif

// *** rtl/dcc_word_fifo.v ***
// Word FIFO with valid/ready on both sides
// Assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module dcc_word_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
)(
  input  wire             i_core_clk,
  input  wire             i_rst,
  input  wire [WIDTH-1:0] i_in_data,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  output wire [WIDTH-1:0] o_out_data,
  output wire             o_out_valid,
  input  wire             i_out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire            empty;
  wire            full;
  wire            push;
  wire            pop;

  // Pointer comparison with wrap bit
  assign empty       = (wr_ptr == rd_ptr);
  assign full        = (wr_ptr[AW] != rd_ptr[AW]) &&
                       (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem[rd_ptr[AW-1:0]];
  assign push        = i_in_valid && !full;
  assign pop         = i_out_ready && !empty;

  // Storage and pointers
  always @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr[AW-1:0]] <= i_in_data;
        wr_ptr              <= wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// *** sim/dcc_monitor_properties.sv ***
// Checker for the debug channel block, bound to its top module
// Assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ns
module dcc_monitor_properties (
  input wire        i_core_clk,
  input wire        i_rst,
  input wire        i_cp_valid,
  input wire        i_cp_write,
  input wire [1:0]  i_cp_reg,
  input wire [31:0] o_cp_rdata,
  input wire        o_cp_rvalid,
  input wire        i_bkpt_match,
  input wire        i_wpt_match,
  input wire        i_ext_abort,
  input wire        i_wpt_reg_update,
  input wire        i_data_range_match,
  input wire        o_prefetch_abort,
  input wire        o_data_abort,
  input wire        o_debug_halt,
  input wire        o_debug_abort_flag,
  input wire        o_monitor_mode
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  // Decoded request kinds and unsuppressed comparator hits
  wire rd  = i_cp_valid && !i_cp_write;
  wire swr = i_cp_valid && i_cp_write && i_cp_reg == 2'h2;
  wire hit = (i_bkpt_match || i_wpt_match) && !i_wpt_reg_update;
  AST_RD_ANSWER:
  assert property (rd |=> o_cp_rvalid)
    else $error("read answer missing");
  AST_RD_IDLE:
  assert property (!rd |=> !o_cp_rvalid)
    else $error("read answer without a read");
  AST_STATUS_LAYOUT:
  assert property (rd && i_cp_reg == 2'h0 |=> o_cp_rdata[31:2] == 30'h0)
    else $error("status upper bits not zero");
  AST_ABORT_SETS:
  assert property (o_monitor_mode && hit && !i_data_range_match
    && !i_ext_abort |=> o_debug_abort_flag)
    else $error("debug abort flag not set");
  AST_EXT_WINS:
  assert property (i_ext_abort && !swr |=> $stable(o_debug_abort_flag))
    else $error("flag changed on external abort");
  AST_BKPT_VECTOR:
  assert property (o_monitor_mode && i_bkpt_match && !i_wpt_match
    && !i_wpt_reg_update && !i_data_range_match |=> o_prefetch_abort)
    else $error("breakpoint did not abort");
  AST_RANGE_BLOCKED:
  assert property (o_monitor_mode && i_data_range_match && !i_ext_abort
    |=> !o_prefetch_abort && !o_data_abort)
    else $error("range match aborted in monitor mode");
  AST_NO_HALT:
  assert property (o_monitor_mode |=> !o_debug_halt)
    else $error("halt raised in monitor mode");
  AST_UPDATE_SUPPRESS:
  assert property (i_wpt_reg_update && !i_ext_abort
    |=> !o_prefetch_abort && !o_data_abort)
    else $error("match during register update");
  AST_RESET_CLEAR:
  assert property (disable iff (1'b0) i_rst |=> !o_debug_abort_flag)
    else $error("abort flag not cleared by reset");
endmodule

bind dcc_monitor dcc_monitor_properties u_dcc_monitor_properties (
  .i_core_clk         (i_core_clk),
  .i_rst              (i_rst),
  .i_cp_valid         (i_cp_valid),
  .i_cp_write         (i_cp_write),
  .i_cp_reg           (i_cp_reg),
  .o_cp_rdata         (o_cp_rdata),
  .o_cp_rvalid        (o_cp_rvalid),
  .i_bkpt_match       (i_bkpt_match),
  .i_wpt_match        (i_wpt_match),
  .i_ext_abort        (i_ext_abort),
  .i_wpt_reg_update   (i_wpt_reg_update),
  .i_data_range_match (i_data_range_match),
  .o_prefetch_abort   (o_prefetch_abort),
  .o_data_abort       (o_data_abort),
  .o_debug_halt       (o_debug_halt),
  .o_debug_abort_flag (o_debug_abort_flag),
  .o_monitor_mode     (o_monitor_mode)
);

// *** sim/dcc_host_model.sv ***
// Host debugger model driving serial scan frames into the block
// Assumes the block samples these pins with its own core clock
`timescale 1ns/1ns
module dcc_host_model (
  output logic o_tck,
  output logic o_tms_sel,
  output logic o_tdi,
  input  wire  i_tdo
);
  // Scan clock stands low outside frames
  initial
  begin
    o_tck = 1'b0;
    o_tms_sel = 1'b0;
    o_tdi = 1'b0;
  end
  // One frame of 36 bits; returns the 32 bits seen on tdo
  task frame(input logic [2:0] sel, input logic wr,
             input logic [31:0] d, output logic [31:0] q);
    logic [35:0] v;
    integer      i;
    begin
      // Channel, identity and control selects only: no vector catch, no comparator
      v = {sel, wr, d};
      o_tms_sel = 1'b1;
      for (i = 0; i < 36; i = i + 1)
      begin
        o_tdi = v[35-i];
        #32 o_tck = 1'b1;
        if (i > 3)
          q[35-i] = i_tdo;
        #32 o_tck = 1'b0;
      end
      #32 o_tms_sel = 1'b0;
      o_tdi = ~o_tdi;  // Released line shows no stale bit
      #96;
    end
  endtask
endmodule

// *** sim/dcc_monitor_tb_top.sv ***
// Self-checking bench for the debug channel block
// Assumes the host model and the bound checker
`timescale 1ns/1ns
module dcc_monitor_tb_top;
  logic        i_core_clk, i_rst, i_cp_valid, i_cp_write;
  logic [1:0]  i_cp_reg;
  logic [31:0] i_cp_wdata, id, w, rq;
  logic        i_bkpt_match, i_wpt_match, i_ext_abort, i_ext_bkpt;
  logic        i_wpt_reg_update, i_data_range_match, i_halt_step_req;
  wire  [31:0] o_cp_rdata;
  wire         o_cp_rvalid, o_pa, o_da, o_dh, o_abt, o_mon, o_tdo;
  wire         tck, tms, tdi;
  logic [31:0] q;
  integer      n_fail, num_checks, seed, i;
  dcc_host_model u_dcc_host_model (.o_tck(tck), .o_tms_sel(tms),
    .o_tdi(tdi), .i_tdo(o_tdo));
  dcc_monitor u_dcc_monitor (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_cp_valid(i_cp_valid), .i_cp_write(i_cp_write),
    .i_cp_reg(i_cp_reg), .i_cp_wdata(i_cp_wdata),
    .o_cp_rdata(o_cp_rdata), .o_cp_rvalid(o_cp_rvalid),
    .i_bkpt_match(i_bkpt_match), .i_wpt_match(i_wpt_match),
    .i_ext_abort(i_ext_abort), .i_halt_step_req(i_halt_step_req),
    .i_ext_bkpt(i_ext_bkpt), .i_wpt_reg_update(i_wpt_reg_update),
    .i_data_range_match(i_data_range_match),
    .o_prefetch_abort(o_pa), .o_data_abort(o_da), .o_debug_halt(o_dh),
    .o_debug_abort_flag(o_abt), .o_monitor_mode(o_mon),
    .i_scan_port_ident_inputs(id), .i_tck(tck), .i_tms_sel(tms),
    .i_tdi(tdi), .o_tdo(o_tdo));
  // Core clock, 8 ns period
  initial
  begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end
  // Count and report one comparison
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // One coprocessor transfer; read data lands in rq
  task cp(input logic wr, input logic [1:0] rg, input logic [31:0] d);
    begin
      @(negedge i_core_clk);
      {i_cp_valid, i_cp_write, i_cp_reg, i_cp_wdata} = {1'b1, wr, rg, d};
      @(negedge i_core_clk);
      i_cp_valid = 1'b0;
      rq = o_cp_rdata;
      if (!wr)
        chk({31'h0, o_cp_rvalid}, 32'h0000_0001);
    end
  endtask
  // Expected {prefetch, data, flag} after one monitor-mode cycle
  function logic [31:0] exp_mon(input logic [5:0] m);
    logic b;
    begin
      b = m[5] & ~m[2] & ~m[1];
      exp_mon = {29'h0, m[3] | b, m[4] & ~m[2] & ~m[1] & ~b,
                 (m[5] | m[4]) & ~m[3] & ~m[2] & ~m[1]};
    end
  endfunction
  task print_verdict;
    begin
      if (n_fail == 0 && num_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Watchdog against a hung handshake
  initial
  begin
    #200000;
    n_fail = n_fail + 1;
    print_verdict;
  end
  initial
  begin
    {n_fail, num_checks, seed} = {32'h0, 32'h0, 32'h0000_7a6b};
    {i_cp_valid, i_cp_write, i_cp_reg, i_cp_wdata} = 36'h0;
    {i_bkpt_match, i_wpt_match, i_ext_abort} = 3'h0;
    {i_wpt_reg_update, i_data_range_match, i_ext_bkpt} = 3'h0;
    i_halt_step_req = 1'b0;
    id = $random(seed);  // Arbitrary identity pin value
    i_rst = 1'b1;
    repeat (8) @(negedge i_core_clk);
    i_rst = 1'b0;
    cp(1'b0, 2'h0, 32'h0);
    chk(rq, 32'h0000_0000);
    cp(1'b1, 2'h2, 32'hFFFF_FFFF);
    cp(1'b0, 2'h2, 32'h0);
    chk(rq, 32'h0000_0001);
    cp(1'b1, 2'h2, 32'h0);
    // Halt mode: step request and breakpoint halt, no abort
    @(negedge i_core_clk);
    {i_halt_step_req, i_bkpt_match} = 2'h3;
    @(negedge i_core_clk);
    chk({28'h0, o_pa, o_da, o_dh, o_abt}, 32'h0000_0002);
    {i_halt_step_req, i_bkpt_match} = 2'h0;
    u_dcc_host_model.frame(3'h4, 1'b1, 32'h0000_0010, q);
    chk({31'h0, o_mon}, 32'h0000_0001);
    u_dcc_host_model.frame(3'h3, 1'b0, 32'h0, q);
    chk(q, {id[31:1], 1'b1});
    // Random match causes, a fixed corner first, flag cleared each pass
    for (i = 0; i < 40; i = i + 1)
    begin
      @(negedge i_core_clk);
      w = $random(seed);
      if (i == 0)
        w[5:0] = 6'h28;  // Breakpoint together with external abort
      {i_bkpt_match, i_wpt_match, i_ext_abort, i_wpt_reg_update,
       i_data_range_match, i_ext_bkpt} = w[5:0];
      @(negedge i_core_clk);
      chk({29'h0, o_pa, o_da, o_abt}, exp_mon(w[5:0]));
      chk({31'h0, o_dh}, 32'h0000_0000);
      {i_bkpt_match, i_wpt_match, i_ext_abort} = 3'h0;
      {i_wpt_reg_update, i_data_range_match, i_ext_bkpt} = 3'h0;
      cp(1'b1, 2'h2, 32'h0);
    end
    // Outgoing word, a refused second write, then scan-out
    w = $random(seed);
    cp(1'b1, 2'h1, w);
    cp(1'b1, 2'h1, ~w);
    cp(1'b0, 2'h0, 32'h0);
    chk(rq, 32'h0000_0002);
    u_dcc_host_model.frame(3'h0, 1'b0, 32'h0, q);
    chk(q, 32'h0000_0002);
    u_dcc_host_model.frame(3'h1, 1'b0, 32'h0, q);
    chk(q, w);
    cp(1'b0, 2'h0, 32'h0);
    chk(rq, 32'h0000_0000);
    // Debugger polls, deposits a word, core read takes it
    u_dcc_host_model.frame(3'h0, 1'b0, 32'h0, q);
    chk(q, 32'h0000_0000);
    w = $random(seed);
    u_dcc_host_model.frame(3'h2, 1'b1, w, q);
    cp(1'b0, 2'h0, 32'h0);
    chk(rq, 32'h0000_0001);
    cp(1'b0, 2'h1, 32'h0);
    chk(rq, w);
    cp(1'b0, 2'h0, 32'h0);
    chk(rq, 32'h0000_0000);
    // Mid-run reset with every flag raised
    cp(1'b1, 2'h1, w);
    cp(1'b1, 2'h2, 32'h0000_0001);
    u_dcc_host_model.frame(3'h2, 1'b1, ~w, q);
    cp(1'b0, 2'h0, 32'h0);
    chk(rq, 32'h0000_0003);
    @(negedge i_core_clk);
    i_rst = 1'b1;
    repeat (2) @(negedge i_core_clk);
    i_rst = 1'b0;
    cp(1'b0, 2'h0, 32'h0);
    chk(rq, 32'h0000_0000);
    cp(1'b0, 2'h2, 32'h0);
    chk(rq, 32'h0000_0000);
    print_verdict;
  end
endmodule
